/* File: pkg/kbh_map.svh */
// kbh_map.svh: offsets, field positions, reset values and ids of the keyboard host port
// assumes inclusion by bare name from pkg/ in the search path
`ifndef KBH_MAP_SVH
`define KBH_MAP_SVH

// ****************************************************************
// host view: offsets from each i/o base address, default base addresses
// ****************************************************************
`define KBH_HOST_DATA_OFS 16'h0000
`define KBH_HOST_CMD_OFS 16'h0000
`define KBH_HOST_BASE0_RST 16'h0060
`define KBH_HOST_BASE1_RST 16'h0064

// ****************************************************************
// logical device numbers
// ****************************************************************
`define KBH_LDN_KEY 8'h06
`define KBH_LDN_MOUSE 8'h05

// ****************************************************************
// embedded-side register offsets
// ****************************************************************
`define KBH_EC_CTRL_OFS 4'h0
`define KBH_EC_IRQ_OFS 4'h2
`define KBH_EC_STAT_OFS 4'h4
`define KBH_EC_KEY_OFS 4'h6
`define KBH_EC_MOUSE_OFS 4'h8
`define KBH_EC_DIN_OFS 4'ha

// ****************************************************************
// status byte fields
// ****************************************************************
`define KBH_ST_OUT_FULL 0
`define KBH_ST_IN_FULL 1
`define KBH_ST_FW_LOW 2
`define KBH_ST_LAST_PORT 3
`define KBH_ST_FW_HI_LSB 4
`define KBH_ST_FW_MASK 8'hf4

// ****************************************************************
// control and irq-control fields
// ****************************************************************
`define KBH_CT_KEY_IRQ_EN 0
`define KBH_CT_MOUSE_IRQ_EN 1
`define KBH_CT_OUT_EMPTY_EN 2
`define KBH_CT_IN_FULL_EN 3
`define KBH_CT_MASK 8'h0f
`define KBH_IR_LEVEL_MODE 0
`define KBH_IR_MASK 8'h01
`define KBH_REG_RST 8'h00

`endif

/* File: pkg/kbh_pkg.sv */
// kbh_pkg: types shared by the keyboard host port files
// assumes nothing beyond a SystemVerilog compiler
package kbh_pkg;

    // which embedded-side register wrote the output buffer last
    typedef enum logic {
        KBH_SRC_KEY,
        KBH_SRC_MOUSE
    } kbh_src_t;

    // host irq signalling style
    typedef enum logic {
        KBH_IRQ_EDGE,
        KBH_IRQ_LEVEL
    } kbh_irq_mode_t;

endpackage

/* File: hw/kbh_byte_buf.sv */
// kbh_byte_buf: one-byte holding buffer with registered read data
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module kbh_byte_buf #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] q
);
    // contents keep the last write; readers see them one edge later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else if (wr_en) begin
            q <= wr_data;
        end
    end
endmodule // kbh_byte_buf

/* File: hw/kbh_port.sv */
// kbh_port: legacy keyboard/mouse controller host port, host i/o side and embedded side
// assumes host i/o cycles and embedded-side accesses arrive as one-cycle strobes on clk
//
// What this block does
// [R1] data-port write sets input-full, clears last-port; command write sets both
// [R2] command-register write sets input-full and last-port to mark a command byte
// [R3] embedded read of its data-in register returns host byte, clears input-full
// [R4] with in-full irq enabled, each host data write pulses embedded line once
// [R5] embedded key-data write sets output-full and raises enabled key host irq
// [R6] embedded mouse-data write sets output-full and raises enabled mouse host irq
// [R7] with out-empty enabled, embedded out-empty line stays high while buffer empty
// [R8] host data read returns buffered byte and clears output-full
// [R9] in level mode a host data read also drops the pending host irq
// [R10] with out-empty enabled, a host data read with no key or mouse write in the same cycle raises embedded out-empty line until the next such write
// [R11] status: firmware bits 7-4 and 2, last-port 3, input-full 1, output-full 0
// [R12] embedded-side status register mirrors the host status byte
// [R13] data port at base 0 offset 0, command/status at base 1 offset 0
// [R14] port shows as logical devices 06h keyboard, 05h mouse; host regs host-only
// [R15] host software should place the two bases at 60h and 64h
// [R16] embedded side polls input-full or takes its irq, then reads the byte
// [R17] key and mouse writes share one buffer; host reads the latest byte
`timescale 1ns/1ps
`include "kbh_map.svh"
module kbh_port
    import kbh_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    // host i/o cycle strobes
    input wire logic [15:0] host_io_base0,
    input wire logic [15:0] host_io_base1,
    input wire logic [15:0] host_io_addr,
    input wire logic host_io_wr,
    input wire logic host_io_rd,
    input wire logic [7:0] host_io_wdata,
    output logic [7:0] host_io_rdata,
    output logic host_io_hit,
    // embedded-side register access
    input wire logic [3:0] ec_addr,
    input wire logic ec_wr,
    input wire logic ec_rd,
    input wire logic [7:0] ec_wdata,
    output logic [7:0] ec_rdata,
    // interrupt lines
    output logic ec_in_full_line,
    output logic ec_out_empty_line,
    output logic host_key_irq,
    output logic host_mouse_irq,
    // logical device numbers
    output logic [7:0] key_logical_device_number,
    output logic [7:0] mouse_logical_device_number
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    logic host_data_sel;
    logic host_cmd_sel;
    logic host_data_wr;
    logic host_cmd_wr;
    logic host_data_rd;
    logic host_stat_rd;
    logic ec_key_wr;
    logic ec_mouse_wr;
    logic ec_din_rd;
    logic ec_ctrl_wr;
    logic ec_irq_wr;
    logic ec_stat_wr;

    // host registers are only reachable through the host strobes
    assign host_data_sel = (host_io_addr == host_io_base0 + `KBH_HOST_DATA_OFS); // [R13] [R14]
    assign host_cmd_sel = (host_io_addr == host_io_base1 + `KBH_HOST_CMD_OFS); // [R13]
    assign host_data_wr = host_io_wr && host_data_sel;
    assign host_cmd_wr = host_io_wr && host_cmd_sel && !host_data_sel;
    assign host_data_rd = host_io_rd && host_data_sel;
    assign host_stat_rd = host_io_rd && host_cmd_sel && !host_data_sel;

    // embedded-side decode
    assign ec_key_wr = ec_wr && (ec_addr == `KBH_EC_KEY_OFS);
    assign ec_mouse_wr = ec_wr && (ec_addr == `KBH_EC_MOUSE_OFS);
    assign ec_din_rd = ec_rd && (ec_addr == `KBH_EC_DIN_OFS);
    assign ec_ctrl_wr = ec_wr && (ec_addr == `KBH_EC_CTRL_OFS);
    assign ec_irq_wr = ec_wr && (ec_addr == `KBH_EC_IRQ_OFS);
    assign ec_stat_wr = ec_wr && (ec_addr == `KBH_EC_STAT_OFS);

    // ****************************************************************
    // byte buffers
    // ****************************************************************
    logic [7:0] in_byte;
    logic [7:0] out_byte;
    logic out_load;
    logic [7:0] out_load_data;

    // one shared output buffer: whichever embedded write came last wins
    assign out_load = ec_key_wr || ec_mouse_wr; // [R17]
    assign out_load_data = ec_wdata;

    // host data and command bytes share the input buffer
    kbh_byte_buf #(
        .WIDTH(8)
    ) u_in_buf (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(host_data_wr || host_cmd_wr),
        .wr_data(host_io_wdata),
        .q(in_byte)
    );

    kbh_byte_buf #(
        .WIDTH(8)
    ) u_out_buf (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(out_load),
        .wr_data(out_load_data),
        .q(out_byte)
    );

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [7:0] ctrl_r;
    logic [7:0] irq_ctrl_r;
    logic [7:0] fw_bits_r;
    kbh_irq_mode_t irq_mode;

    // control bits steer the four interrupt paths
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r <= `KBH_REG_RST;
        end else if (ec_ctrl_wr) begin
            ctrl_r <= ec_wdata & `KBH_CT_MASK;
        end
    end

    // host irq style: bit set selects level mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_ctrl_r <= `KBH_REG_RST;
        end else if (ec_irq_wr) begin
            irq_ctrl_r <= ec_wdata & `KBH_IR_MASK;
        end
    end

    assign irq_mode = irq_ctrl_r[`KBH_IR_LEVEL_MODE] ? KBH_IRQ_LEVEL : KBH_IRQ_EDGE;

    // firmware general-purpose bits, written only from the embedded side
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fw_bits_r <= `KBH_REG_RST;
        end else if (ec_stat_wr) begin
            fw_bits_r <= ec_wdata & `KBH_ST_FW_MASK; // [R11]
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    logic in_full_flag_r;
    logic last_write_port_flag_r;
    logic output_full_flag_r;
    kbh_src_t out_src_r;

    // a host write landing with the embedded read keeps the flag set
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            in_full_flag_r <= 1'b0;
        end else if (host_data_wr || host_cmd_wr) begin
            in_full_flag_r <= 1'b1; // [R1] [R2]
        end else if (ec_din_rd) begin
            in_full_flag_r <= 1'b0; // [R3]
        end
    end

    // remembers which port the host wrote last
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_write_port_flag_r <= 1'b0;
        end else if (host_data_wr) begin
            last_write_port_flag_r <= 1'b0; // [R1]
        end else if (host_cmd_wr) begin
            last_write_port_flag_r <= 1'b1; // [R1] [R2]
        end
    end

    // embedded write beats a simultaneous host read so no byte is lost
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            output_full_flag_r <= 1'b0;
        end else if (out_load) begin
            output_full_flag_r <= 1'b1; // [R5] [R6]
        end else if (host_data_rd) begin
            output_full_flag_r <= 1'b0; // [R8]
        end
    end

    // source of the latest output byte
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_src_r <= KBH_SRC_KEY;
        end else if (ec_mouse_wr) begin
            out_src_r <= KBH_SRC_MOUSE; // [R17]
        end else if (ec_key_wr) begin
            out_src_r <= KBH_SRC_KEY; // [R17]
        end
    end

    // ****************************************************************
    // status byte and read paths
    // ****************************************************************
    logic [7:0] status_byte;

    always_comb begin
        status_byte = fw_bits_r; // [R11]
        status_byte[`KBH_ST_LAST_PORT] = last_write_port_flag_r; // [R11]
        status_byte[`KBH_ST_IN_FULL] = in_full_flag_r; // [R11]
        status_byte[`KBH_ST_OUT_FULL] = output_full_flag_r; // [R11]
    end

    // host read data registered; hit marks a decoded host cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_io_rdata <= 8'h00;
            host_io_hit <= 1'b0;
        end else begin
            host_io_hit <= (host_io_rd || host_io_wr) && (host_data_sel || host_cmd_sel);
            if (host_data_rd) begin
                host_io_rdata <= out_byte; // [R8]
            end else if (host_stat_rd) begin
                host_io_rdata <= status_byte; // [R11]
            end else begin
                host_io_rdata <= 8'h00;
            end
        end
    end

    // embedded read mux; unmapped offsets read zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ec_rdata <= 8'h00;
        end else if (ec_rd) begin
            unique case (ec_addr)
                `KBH_EC_CTRL_OFS: ec_rdata <= ctrl_r;
                `KBH_EC_IRQ_OFS: ec_rdata <= irq_ctrl_r;
                `KBH_EC_STAT_OFS: ec_rdata <= status_byte; // [R12]
                `KBH_EC_KEY_OFS: ec_rdata <= out_byte;
                `KBH_EC_MOUSE_OFS: ec_rdata <= out_byte;
                `KBH_EC_DIN_OFS: ec_rdata <= in_byte; // [R3]
                default: ec_rdata <= 8'h00;
            endcase
        end else begin
            ec_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // embedded-side interrupts
    // ****************************************************************
    // one pulse per host data write; command writes are left to polling
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ec_in_full_line <= 1'b0;
        end else begin
            ec_in_full_line <= host_data_wr && ctrl_r[`KBH_CT_IN_FULL_EN]; // [R4]
        end
    end

    // level while empty; a host read empties it, which raises the line as the flag clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ec_out_empty_line <= 1'b0;
        end else begin
            ec_out_empty_line <= ctrl_r[`KBH_CT_OUT_EMPTY_EN] &&
                ((!output_full_flag_r && !out_load) || (host_data_rd && !out_load)); // [R7] [R10]
        end
    end

    // ****************************************************************
    // host interrupts
    // ****************************************************************
    // level mode holds until the host reads or the other device's data is written; edge mode gives one pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_key_irq <= 1'b0;
        end else if (ec_key_wr && ctrl_r[`KBH_CT_KEY_IRQ_EN]) begin
            host_key_irq <= 1'b1; // [R5]
        end else if (irq_mode == KBH_IRQ_EDGE) begin
            host_key_irq <= 1'b0;
        end else if (host_data_rd || ec_mouse_wr) begin
            host_key_irq <= 1'b0; // [R9]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            host_mouse_irq <= 1'b0;
        end else if (ec_mouse_wr && ctrl_r[`KBH_CT_MOUSE_IRQ_EN]) begin
            host_mouse_irq <= 1'b1; // [R6]
        end else if (irq_mode == KBH_IRQ_EDGE) begin
            host_mouse_irq <= 1'b0;
        end else if (host_data_rd || ec_key_wr) begin
            host_mouse_irq <= 1'b0; // [R9]
        end
    end

    // ****************************************************************
    // logical device numbers
    // ****************************************************************
    // fixed numbers held in flops so the outputs are registered
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            key_logical_device_number <= `KBH_LDN_KEY; // [R14]
            mouse_logical_device_number <= `KBH_LDN_MOUSE; // [R14]
        end else begin
            key_logical_device_number <= `KBH_LDN_KEY;
            mouse_logical_device_number <= `KBH_LDN_MOUSE;
        end
    end

endmodule // kbh_port

/* File: sim/kbh_port_sva.sv */
// kbh_port_sva: port-level checks of the keyboard host port
// assumes a bind onto kbh_port, one clock, async active-low reset
`timescale 1ns/1ps
module kbh_port_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] host_io_base0,
    input wire logic [15:0] host_io_base1,
    input wire logic [15:0] host_io_addr,
    input wire logic host_io_wr,
    input wire logic host_io_rd,
    input wire logic [7:0] host_io_rdata,
    input wire logic host_io_hit,
    input wire logic [3:0] ec_addr,
    input wire logic ec_wr,
    input wire logic ec_rd,
    input wire logic [7:0] ec_wdata,
    input wire logic ec_in_full_line,
    input wire logic ec_out_empty_line,
    input wire logic host_key_irq,
    input wire logic [7:0] key_logical_device_number,
    input wire logic [7:0] mouse_logical_device_number
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // decoded strobes; command/status only counts when the bases differ
    logic dwr, cwr, drd, crd, dec;
    assign dwr = host_io_wr && host_io_addr == host_io_base0;
    assign drd = host_io_rd && host_io_addr == host_io_base0;
    assign cwr = host_io_wr && host_io_addr == host_io_base1 && host_io_base0 != host_io_base1;
    assign crd = host_io_rd && host_io_addr == host_io_base1 && host_io_base0 != host_io_base1;
    assign dec = (host_io_wr || host_io_rd)
        && (host_io_addr == host_io_base0 || host_io_addr == host_io_base1);
    // ****************************************************************
    // properties
    // ****************************************************************
    property p_data_hit; dwr || drd |=> host_io_hit; endproperty
    a_data_hit: assert property (p_data_hit) else $error("data port strobe missed");
    property p_no_hit; !dec |=> !host_io_hit; endproperty
    a_no_hit: assert property (p_no_hit) else $error("hit without decode");
    property p_ldn;
        key_logical_device_number == 8'h06 && mouse_logical_device_number == 8'h05;
    endproperty
    a_ldn: assert property (p_ldn) else $error("device number wrong");
    property p_rd_idle; !host_io_rd |=> host_io_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
    property p_in_cause; ec_in_full_line |-> $past(dwr); endproperty
    a_in_cause: assert property (p_in_cause) else $error("in-full pulse uncaused");
    property p_cmd_st;
        cwr ##1 !(host_io_wr || ec_rd) ##1 crd |=> host_io_rdata[3] && host_io_rdata[1];
    endproperty
    a_cmd_st: assert property (p_cmd_st) else $error("command flags wrong");
    property p_dat_st;
        dwr ##1 !(host_io_wr || ec_rd) ##1 crd |=> !host_io_rdata[3] && host_io_rdata[1];
    endproperty
    a_dat_st: assert property (p_dat_st) else $error("data flags wrong");
    // three quiet cycles between the key write and the host read, as the bench issues them
    property p_key_back;
        ec_wr && ec_addr == 4'h6 ##1 !ec_wr [*3] ##1 drd |=> host_io_rdata == $past(ec_wdata, 5);
    endproperty
    a_key_back: assert property (p_key_back) else $error("latest byte lost");
    property p_full_low;
        ec_wr && (ec_addr == 4'h6 || ec_addr == 4'h8) |=> !ec_out_empty_line;
    endproperty
    a_full_low: assert property (p_full_low) else $error("empty line while full");
    c_cmd: cover property (cwr);
    c_in_full: cover property (ec_in_full_line);
    c_key_irq: cover property (host_key_irq);
endmodule // kbh_port_sva

bind kbh_port kbh_port_sva i_kbh_port_sva (.clk(clk), .arst_n(arst_n),
    .host_io_base0(host_io_base0), .host_io_base1(host_io_base1),
    .host_io_addr(host_io_addr), .host_io_wr(host_io_wr), .host_io_rd(host_io_rd),
    .host_io_rdata(host_io_rdata), .host_io_hit(host_io_hit), .ec_addr(ec_addr),
    .ec_wr(ec_wr), .ec_rd(ec_rd), .ec_wdata(ec_wdata), .ec_in_full_line(ec_in_full_line),
    .ec_out_empty_line(ec_out_empty_line), .host_key_irq(host_key_irq),
    .key_logical_device_number(key_logical_device_number),
    .mouse_logical_device_number(mouse_logical_device_number));

/* File: sim/kbh_host_model.sv */
// kbh_host_model: host processor issuing i/o cycles to the keyboard host port
// assumes strobes taken on the rising edge, read data one cycle later
`timescale 1ns/1ps
module kbh_host_model (
    input wire logic clk,
    output logic [15:0] host_io_base0,
    output logic [15:0] host_io_base1,
    output logic [15:0] host_io_addr,
    output logic host_io_wr,
    output logic host_io_rd,
    output logic [7:0] host_io_wdata,
    input wire logic [7:0] host_io_rdata
);
    // legacy placement of the two bases
    assign host_io_base0 = 16'h0060;
    assign host_io_base1 = 16'h0064;
    initial begin
        host_io_addr = 16'h0000;
        host_io_wr = 1'b0;
        host_io_rd = 1'b0;
        host_io_wdata = 8'h00;
    end
    // one i/o cycle; address and data are inverted afterwards so the
    // port cannot lean on a stale value
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clk);
        host_io_wr <= w;
        host_io_rd <= !w;
        host_io_addr <= a;
        host_io_wdata <= d;
        @(posedge clk);
        host_io_wr <= 1'b0;
        host_io_rd <= 1'b0;
        host_io_addr <= ~a;
        host_io_wdata <= ~d;
        @(negedge clk);
        q = host_io_rdata;
    endtask
endmodule // kbh_host_model

/* File: sim/tb_top.sv */
// tb_top: self-checking bench of the keyboard host port against a flag model
// assumes the host model drives the host side, this bench the embedded side
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
    logic clk, arst_n, wr, rd, hit, ec_wr, ec_rd, in_line, out_line, k_irq, m_irq;
    logic [15:0] base0, base1, addr;
    logic [7:0] wdata, rdata, ec_wdata, ec_rdata, k_ldn, m_ldn, q, d;
    logic [3:0] ec_addr;
    logic [31:0] rnd;
    logic m_ibf, m_a2, m_obf;
    logic [7:0] m_fw, m_in, m_out, m_ctrl;
    int bad_count, compares, cyc;
    kbh_host_model i_host (.clk(clk), .host_io_base0(base0), .host_io_base1(base1),
        .host_io_addr(addr), .host_io_wr(wr), .host_io_rd(rd), .host_io_wdata(wdata),
        .host_io_rdata(rdata));
    kbh_port i_kbh_port (.clk(clk), .arst_n(arst_n), .host_io_base0(base0),
        .host_io_base1(base1), .host_io_addr(addr), .host_io_wr(wr), .host_io_rd(rd),
        .host_io_wdata(wdata), .host_io_rdata(rdata), .host_io_hit(hit),
        .ec_addr(ec_addr), .ec_wr(ec_wr), .ec_rd(ec_rd), .ec_wdata(ec_wdata),
        .ec_rdata(ec_rdata), .ec_in_full_line(in_line), .ec_out_empty_line(out_line),
        .host_key_irq(k_irq), .host_mouse_irq(m_irq), .key_logical_device_number(k_ldn),
        .mouse_logical_device_number(m_ldn));
    // ****************************************************************
    // clock, timeout and helpers
    // ****************************************************************
    initial clk = 1'b0;
    always #2 clk = ~clk;
    // the whole run needs under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            complete_run();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] st();
        return {m_fw[7:4], m_a2, m_fw[2], m_ibf, m_obf};
    endfunction
    task automatic ec(input logic w, input logic [3:0] a, input logic [7:0] dv);
        @(posedge clk);
        ec_wr <= w;
        ec_rd <= !w;
        ec_addr <= a;
        ec_wdata <= dv;
        @(posedge clk);
        ec_wr <= 1'b0;
        ec_rd <= 1'b0;
        ec_addr <= ~a;
        ec_wdata <= ~dv;
        @(negedge clk);
        q = ec_rdata;
    endtask
    task automatic chk_st();
        i_host.io(1'b0, base1, 8'h00, q);
        `CHK("host status", st(), q)
        ec(1'b0, 4'h4, 8'h00);
        `CHK("ec status", st(), q)
    endtask
    task automatic complete_run();
        if (bad_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {arst_n, ec_wr, ec_rd, ec_addr, ec_wdata} = '0;
        {m_ibf, m_a2, m_obf, m_fw, m_in, m_out} = '0;
        rnd = 32'h3505c4b4;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        `CHK("key ldn", 8'h06, k_ldn)
        `CHK("mouse ldn", 8'h05, m_ldn)
        chk_st();
        for (int p = 0; p < 2; p++) begin
            rnd = lfsr(rnd);
            m_ctrl = p ? (rnd[7:0] & 8'h0f) : 8'h0f;
            m_fw = rnd[15:8] & 8'hf4;
            ec(1'b1, 4'h0, m_ctrl);
            ec(1'b1, 4'h4, rnd[15:8]);
            ec(1'b0, 4'h0, 8'h00);
            `CHK("control", m_ctrl, q)
            for (int i = 0; i < 40; i++) begin
                rnd = lfsr(rnd);
                d = rnd[7:0];
                case (rnd[10:8] % 6)
                    0: begin
                        i_host.io(1'b1, base0, d, q);
                        `CHK("in-full line", m_ctrl[3], in_line)
                        {m_ibf, m_a2, m_in} = {2'b10, d};
                    end
                    1: begin
                        i_host.io(1'b1, base1, d, q);
                        `CHK("in-full line", 1'b0, in_line)
                        {m_ibf, m_a2, m_in} = {2'b11, d};
                    end
                    2: begin
                        ec(1'b0, 4'ha, 8'h00);
                        `CHK("data in", m_in, q)
                        m_ibf = 1'b0;
                    end
                    3, 4: begin
                        ec(1'b1, rnd[8] ? 4'h8 : 4'h6, d);
                        `CHK("key irq", m_ctrl[0] & !rnd[8], k_irq)
                        `CHK("mouse irq", m_ctrl[1] & rnd[8], m_irq)
                        `CHK("out-empty line", 1'b0, out_line)
                        {m_obf, m_out} = {1'b1, d};
                    end
                    default: begin
                        i_host.io(1'b0, base0, 8'h00, q);
                        `CHK("data out", m_out, q)
                        `CHK("out-empty line", m_ctrl[2], out_line)
                        m_obf = 1'b0;
                    end
                endcase
                chk_st();
            end
        end
        // level mode keeps the key irq up until the host drains the byte
        ec(1'b1, 4'h0, 8'h0f);
        ec(1'b1, 4'h2, 8'h01);
        ec(1'b1, 4'h6, 8'h5a);
        repeat (2) @(negedge clk);
        `CHK("held irq", 1'b1, k_irq)
        i_host.io(1'b0, base0, 8'h00, q);
        `CHK("data out", 8'h5a, q)
        `CHK("held irq", 1'b0, k_irq)
        m_obf = 1'b0;
        // a cycle outside both ports must leave every flag alone
        i_host.io(1'b1, 16'h0070, 8'h33, q);
        `CHK("in-full line", 1'b0, in_line)
        chk_st();
        ec(1'b0, 4'hc, 8'h00);
        `CHK("unmapped", 8'h00, q)
        complete_run();
    end
endmodule // tb_top
